// file: rrc_pkg.sv
// constants and carrier types for the reservation release command block
`default_nettype none
package rrc_pkg;
	// register byte offsets, one aligned word each
	localparam logic [7:0] OFS_DW10   = 8'h00; // command dword 10
	localparam logic [7:0] OFS_PTR0   = 8'h04; // buffer pointer bits 31:0
	localparam logic [7:0] OFS_PTR1   = 8'h08; // buffer pointer bits 63:32
	localparam logic [7:0] OFS_PTR2   = 8'h0c; // buffer pointer bits 95:64
	localparam logic [7:0] OFS_PTR3   = 8'h10; // buffer pointer bits 127:96
	localparam logic [7:0] OFS_CTRL   = 8'h14; // go and pointer mode
	localparam logic [7:0] OFS_STATUS = 8'h18; // busy, done, last status
	localparam logic [7:0] OFS_HELD   = 8'h1c; // reservation kind held
	localparam logic [7:0] OFS_KEY_LO = 8'h20; // registered key low word
	localparam logic [7:0] OFS_KEY_HI = 8'h24; // registered key high word
	localparam logic [7:0] OFS_GEN    = 8'h28; // generation counter
	localparam logic [7:0] OFS_QID    = 8'h2c; // submitting queue id
	localparam int unsigned PTR_WORDS = 4;    // 128-bit pointer in words
	// control and status field positions
	localparam int unsigned CTRL_GO_BIT   = 0;
	localparam int unsigned CTRL_SGL_BIT  = 1;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_DONE_BIT = 1;
	localparam int unsigned STAT_SC_LSB   = 8;
	// action codes and status codes
	localparam logic [2:0] ACT_RELEASE = 3'h0;
	localparam logic [2:0] ACT_CLEAR   = 3'h1;
	localparam logic [7:0] SC_SUCCESS       = 8'h00;
	localparam logic [7:0] SC_INVALID_FIELD = 8'h02;
	localparam logic [7:0] SC_RES_CONFLICT  = 8'h83;
	localparam logic [7:0] KIND_NONE        = 8'h00;
	// page geometry for splitting the two key dwords across entries
	localparam logic [11:0] PAGE_LAST_DW = 12'hffc;
	localparam logic [63:0] DW_STEP      = 64'h4;
	localparam logic [31:0] GEN_STEP     = 32'h1;
	// command dword 10 layout
	typedef struct packed {
		logic [15:0] rsvd_hi;           // reserved 31:16
		logic [7:0]  reservation_kind;  // 15:8
		logic [3:0]  rsvd_lo;           // reserved 7:4
		logic        key_check_bypass;  // 3
		logic [2:0]  release_action;    // 2:0
	} rrc_dw10_t;
	// completion entry handed to the completion queue writer
	typedef struct packed {
		logic [15:0] queue_id;          // submitting queue
		logic [7:0]  status;            // status code
	} rrc_cpl_t;
	// reserved action test, used by the sequencer and its checks
	function automatic logic rrc_action_reserved(input logic [2:0] act);
		rrc_action_reserved = (act != ACT_RELEASE) && (act != ACT_CLEAR);
	endfunction
endpackage
`default_nettype wire

// file: rrc_key_fetch.sv
// host memory reader that brings in the 8-byte current reservation key
`timescale 1ns/1ps
`default_nettype none
module rrc_key_fetch
	import rrc_pkg::*;
#(
	parameter int unsigned ADDR_W = 64
)(
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              start_in,
	input  wire logic [ADDR_W-1:0] addr0_in,
	input  wire logic [ADDR_W-1:0] addr1_in,
	output logic                   mem_req_valid_out,
	input  wire logic              mem_req_ready_in,
	output logic [ADDR_W-1:0]      mem_req_addr_out,
	input  wire logic              mem_rsp_valid_in,
	input  wire logic [31:0]       mem_rsp_data_in,
	output logic [63:0]            key_out,
	output logic                   done_out
);
	// one-hot fetch states
	typedef enum logic [4:0] {
		F_IDLE  = 5'b00001,
		F_REQ0  = 5'b00010,
		F_WAIT0 = 5'b00100,
		F_REQ1  = 5'b01000,
		F_WAIT1 = 5'b10000
	} rrc_fetch_t;

	rrc_fetch_t        state_reg;  // fetch state
	logic [ADDR_W-1:0] addr_reg;   // address being requested
	logic [ADDR_W-1:0] addr1_reg;  // second dword address
	logic [63:0]       key_reg;    // assembled key, low dword first
	logic              done_reg;   // one-cycle completion pulse

	// request is valid only in the two request states
	assign mem_req_valid_out = (state_reg == F_REQ0) || (state_reg == F_REQ1);
	assign mem_req_addr_out  = addr_reg;
	assign key_out           = key_reg;
	assign done_out          = done_reg;

	// sequencing of the two dword reads
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_reg <= F_IDLE;
		end
		else
		begin
			case (state_reg)
				F_IDLE:  if (start_in) state_reg <= F_REQ0;
				F_REQ0:  if (mem_req_ready_in) state_reg <= F_WAIT0;
				F_WAIT0: if (mem_rsp_valid_in) state_reg <= F_REQ1;
				F_REQ1:  if (mem_req_ready_in) state_reg <= F_WAIT1;
				F_WAIT1: if (mem_rsp_valid_in) state_reg <= F_IDLE;
				default: state_reg <= F_IDLE;
			endcase
		end
	end

	// addresses: first dword, then the one the caller computed
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			addr_reg  <= '0;
			addr1_reg <= '0;
		end
		else if (state_reg == F_IDLE && start_in)
		begin
			addr_reg  <= addr0_in;
			addr1_reg <= addr1_in;
		end
		else if (state_reg == F_WAIT0 && mem_rsp_valid_in)
		begin
			addr_reg <= addr1_reg;
		end
	end

	// key assembly, structure bytes 7:0, little endian dwords
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			key_reg  <= '0;
			done_reg <= 1'b0;
		end
		else
		begin
			done_reg <= (state_reg == F_WAIT1) && mem_rsp_valid_in;
			if (state_reg == F_WAIT0 && mem_rsp_valid_in)
				key_reg[31:0] <= mem_rsp_data_in;
			if (state_reg == F_WAIT1 && mem_rsp_valid_in)
				key_reg[63:32] <= mem_rsp_data_in;
		end
	end

	// the second request goes out at the second dword address
	a_req_addr_order: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_reg == F_WAIT0 && mem_rsp_valid_in) |=> ##[0:300]
		(mem_req_valid_out && mem_req_addr_out == $past(addr1_reg)))
		else $error("second read not at second dword address");

	// the last dword lands in the high half with a done pulse
	a_key_high_done: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_reg == F_WAIT1 && mem_rsp_valid_in) |=>
		(done_out && key_out[63:32] == $past(mem_rsp_data_in)) ##1 !done_out)
		else $error("key high dword or done pulse wrong");
endmodule // rrc_key_fetch
`default_nettype wire

// file: rrc_release.sv
// reservation release command sequencer with its register slave
`timescale 1ns/1ps
`default_nettype none
module rrc_release
	import rrc_pkg::*;
#(
	parameter int unsigned ADDR_W = 64
)(
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	// register bus, avalon-mm slave
	input  wire logic [7:0]        avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	input  wire logic [3:0]        avs_byteenable_in,
	output logic [31:0]            avs_readdata_out,
	output logic                   avs_waitrequest_out,
	// host memory read port
	output logic                   mem_req_valid_out,
	input  wire logic              mem_req_ready_in,
	output logic [ADDR_W-1:0]      mem_req_addr_out,
	input  wire logic              mem_rsp_valid_in,
	input  wire logic [31:0]       mem_rsp_data_in,
	// completion entry to the completion queue writer
	output logic                   cpl_valid_out,
	output rrc_cpl_t               cpl_entry_out,
	input  wire logic              cpl_ready_in
);
	// one-hot command states
	typedef enum logic [4:0] {
		S_IDLE   = 5'b00001,
		S_DECODE = 5'b00010,
		S_FETCH  = 5'b00100,
		S_CHECK  = 5'b01000,
		S_POST   = 5'b10000
	} rrc_state_t;

	rrc_state_t  state_reg;               // command state
	rrc_dw10_t   dw10_reg;                // software copy of dword 10
	rrc_dw10_t   cmd_reg;                 // snapshot taken at go
	logic [31:0] ptr_reg [PTR_WORDS];     // buffer pointer words
	logic        sgl_reg;                 // pointer mode, 1 = sgl
	logic [7:0]  held_kind_reg;           // reservation kind held
	logic [63:0] reg_key_reg;             // registered key
	logic [31:0] gen_reg;                 // generation counter
	logic [15:0] qid_reg;                 // submitting queue id
	logic        done_reg;                // sticky command-done flag
	logic [7:0]  sc_reg;                  // status of last command
	rrc_cpl_t    cpl_reg;                 // completion being posted
	logic        ack_reg;                 // bus answer phase
	logic [31:0] rdata_reg;               // bus read data
	logic        go_reg;                  // start pulse from a write
	logic        fetch_start;             // kick to the key reader
	logic        fetch_done;              // key reader finished
	logic [63:0] fetched_key;             // current reservation key
	logic [63:0] addr0;                   // first key dword address
	logic [63:0] addr1;                   // second key dword address
	logic        key_ok;                  // key matched or bypassed
	logic        wr_take;                 // write accepted this edge
	logic        busy;                    // command in flight

	// merge a write under its byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++)
			if (be[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
		be_merge = res;
	endfunction

	// one wait cycle per access, then the answer edge
	assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack_reg;
	assign avs_readdata_out    = rdata_reg;
	assign wr_take             = avs_write_in && ack_reg;
	assign busy                = (state_reg != S_IDLE);

	// bus answer phase toggles once per request
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			ack_reg <= 1'b0;
		else
			ack_reg <= (avs_read_in || avs_write_in) && !ack_reg;
	end

	// read mux captured in the wait cycle, unmapped reads as zero
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			rdata_reg <= '0;
		else if (avs_read_in && !ack_reg)
		begin
			if (avs_address_in == OFS_DW10)
				rdata_reg <= dw10_reg;
			else if (avs_address_in == OFS_PTR0)
				rdata_reg <= ptr_reg[0];
			else if (avs_address_in == OFS_PTR1)
				rdata_reg <= ptr_reg[1];
			else if (avs_address_in == OFS_PTR2)
				rdata_reg <= ptr_reg[2];
			else if (avs_address_in == OFS_PTR3)
				rdata_reg <= ptr_reg[3];
			else if (avs_address_in == OFS_CTRL)
				rdata_reg <= 32'(sgl_reg) << CTRL_SGL_BIT;
			else if (avs_address_in == OFS_STATUS)
				rdata_reg <= (32'(busy) << STAT_BUSY_BIT)
					| (32'(done_reg) << STAT_DONE_BIT)
					| (32'(sc_reg) << STAT_SC_LSB);
			else if (avs_address_in == OFS_HELD)
				rdata_reg <= 32'(held_kind_reg);
			else if (avs_address_in == OFS_KEY_LO)
				rdata_reg <= reg_key_reg[31:0];
			else if (avs_address_in == OFS_KEY_HI)
				rdata_reg <= reg_key_reg[63:32];
			else if (avs_address_in == OFS_GEN)
				rdata_reg <= gen_reg;
			else if (avs_address_in == OFS_QID)
				rdata_reg <= 32'(qid_reg);
			else
				rdata_reg <= '0;
		end
	end

	// command words; locked while busy so the snapshot stays valid
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			dw10_reg <= '0;
			sgl_reg  <= 1'b0;
			qid_reg  <= '0;
			for (int i = 0; i < PTR_WORDS; i++)
				ptr_reg[i] <= '0;
		end
		else if (wr_take && !busy)
		begin
			if (avs_address_in == OFS_DW10)
				dw10_reg <= be_merge(dw10_reg, avs_writedata_in,
					avs_byteenable_in);
			else if (avs_address_in == OFS_CTRL && avs_byteenable_in[0])
				sgl_reg <= avs_writedata_in[CTRL_SGL_BIT];
			else if (avs_address_in == OFS_QID)
				qid_reg <= 16'(be_merge(32'(qid_reg), avs_writedata_in,
					avs_byteenable_in));
			for (int i = 0; i < PTR_WORDS; i++)
				if (avs_address_in == OFS_PTR0 + 8'(i * 4))
					ptr_reg[i] <= be_merge(ptr_reg[i], avs_writedata_in,
						avs_byteenable_in);
		end
	end

	// go is refused while a command is in flight
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			go_reg <= 1'b0;
		else
			go_reg <= wr_take && !busy && avs_address_in == OFS_CTRL
				&& avs_byteenable_in[0] && avs_writedata_in[CTRL_GO_BIT];
	end

	// key location: prp page end splits the key onto prp entry 2
	assign addr0 = {ptr_reg[1], ptr_reg[0]};
	assign addr1 = (!sgl_reg && addr0[11:0] == PAGE_LAST_DW)
		? {ptr_reg[3], ptr_reg[2]} : addr0 + DW_STEP;
	assign fetch_start = (state_reg == S_DECODE)
		&& !rrc_action_reserved(cmd_reg.release_action);

	// structure read, host memory toward the controller
	rrc_key_fetch #(
		.ADDR_W (ADDR_W)
	) u_fetch (
		.clock_in          (clock_in),
		.rst_in            (rst_in),
		.start_in          (fetch_start),
		.addr0_in          (addr0[ADDR_W-1:0]),
		.addr1_in          (addr1[ADDR_W-1:0]),
		.mem_req_valid_out (mem_req_valid_out),
		.mem_req_ready_in  (mem_req_ready_in),
		.mem_req_addr_out  (mem_req_addr_out),
		.mem_rsp_valid_in  (mem_rsp_valid_in),
		.mem_rsp_data_in   (mem_rsp_data_in),
		.key_out           (fetched_key),
		.done_out          (fetch_done)
	);

	// bypass set means the supplied key is never compared
	assign key_ok = cmd_reg.key_check_bypass
		|| (fetched_key == reg_key_reg);

	// command sequencing
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_reg <= S_IDLE;
			cmd_reg   <= '0;
		end
		else
		begin
			case (state_reg)
				S_IDLE:
					if (go_reg)
					begin
						state_reg <= S_DECODE;
						cmd_reg   <= dw10_reg;
					end
				S_DECODE:
					// reserved action skips the fetch entirely
					if (rrc_action_reserved(cmd_reg.release_action))
						state_reg <= S_POST;
					else
						state_reg <= S_FETCH;
				S_FETCH:  if (fetch_done) state_reg <= S_CHECK;
				S_CHECK:  state_reg <= S_POST;
				S_POST:   if (cpl_ready_in) state_reg <= S_IDLE;
				default:  state_reg <= S_IDLE;
			endcase
		end
	end

	// completion status; reserved bits of dword 10 are not checked
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			cpl_reg <= '0;
		else if (state_reg == S_DECODE
			&& rrc_action_reserved(cmd_reg.release_action))
			cpl_reg <= '{queue_id: qid_reg, status: SC_INVALID_FIELD};
		else if (state_reg == S_CHECK)
		begin
			cpl_reg.queue_id <= qid_reg;
			if (!key_ok)
				cpl_reg.status <= SC_RES_CONFLICT;
			else if (cmd_reg.release_action == ACT_RELEASE
				&& held_kind_reg != KIND_NONE
				&& cmd_reg.reservation_kind != held_kind_reg)
				cpl_reg.status <= SC_INVALID_FIELD;
			else
				cpl_reg.status <= SC_SUCCESS;
		end
	end

	assign cpl_valid_out = (state_reg == S_POST);
	assign cpl_entry_out = cpl_reg;

	// reservation state: hardware update wins over a software write
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			held_kind_reg <= KIND_NONE;
			gen_reg       <= '0;
		end
		else if (state_reg == S_CHECK && key_ok)
		begin
			if (cmd_reg.release_action == ACT_CLEAR)
			begin
				held_kind_reg <= KIND_NONE;
				gen_reg       <= gen_reg + GEN_STEP;
			end
			else if (cmd_reg.reservation_kind == held_kind_reg)
				held_kind_reg <= KIND_NONE;
		end
		else if (wr_take && !busy && avs_address_in == OFS_HELD
			&& avs_byteenable_in[0])
			held_kind_reg <= avs_writedata_in[7:0];
	end

	// registered key, set by software from the register flow
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
			reg_key_reg <= '0;
		else if (wr_take && !busy && avs_address_in == OFS_KEY_LO)
			reg_key_reg[31:0] <= be_merge(reg_key_reg[31:0],
				avs_writedata_in, avs_byteenable_in);
		else if (wr_take && !busy && avs_address_in == OFS_KEY_HI)
			reg_key_reg[63:32] <= be_merge(reg_key_reg[63:32],
				avs_writedata_in, avs_byteenable_in);
	end

	// done flag: setting at post wins over a write-one clear
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			done_reg <= 1'b0;
			sc_reg   <= SC_SUCCESS;
		end
		else if (cpl_valid_out && cpl_ready_in)
		begin
			done_reg <= 1'b1;
			sc_reg   <= cpl_reg.status;
		end
		else if (wr_take && avs_address_in == OFS_STATUS
			&& avs_byteenable_in[0] && avs_writedata_in[STAT_DONE_BIT])
			done_reg <= 1'b0;
	end

	// named steps of a checked release
	sequence s_release_checked;
		state_reg == S_CHECK && cmd_reg.release_action == ACT_RELEASE;
	endsequence
	sequence s_posted(logic [7:0] sc);
		cpl_valid_out && cpl_entry_out.status == sc;
	endsequence

	a_reserved_action: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_reg == S_DECODE && rrc_action_reserved(cmd_reg.release_action))
		|=> s_posted(SC_INVALID_FIELD) and $stable(held_kind_reg)
		and !mem_req_valid_out)
		else $error("reserved action not rejected cleanly");

	a_kind_mismatch: assert property (@(posedge clock_in) disable iff (rst_in)
		(s_release_checked and (key_ok && held_kind_reg != KIND_NONE
		&& cmd_reg.reservation_kind != held_kind_reg))
		|=> s_posted(SC_INVALID_FIELD) and $stable(held_kind_reg))
		else $error("kind mismatch did not fail");

	a_bypass_release: assert property (@(posedge clock_in) disable iff (rst_in)
		(s_release_checked and (cmd_reg.key_check_bypass
		&& cmd_reg.reservation_kind == held_kind_reg))
		|=> s_posted(SC_SUCCESS) and held_kind_reg == KIND_NONE)
		else $error("bypass release did not succeed");

	a_key_conflict: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_reg == S_CHECK && !cmd_reg.key_check_bypass
		&& fetched_key != reg_key_reg)
		|=> s_posted(SC_RES_CONFLICT) and $stable(held_kind_reg))
		else $error("key mismatch not reported");

	a_clear_bumps_gen: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_reg == S_CHECK && key_ok
		&& cmd_reg.release_action == ACT_CLEAR)
		|=> held_kind_reg == KIND_NONE && gen_reg == $past(gen_reg) + GEN_STEP)
		else $error("clear did not empty state and bump generation");

	a_one_completion: assert property (@(posedge clock_in) disable iff (rst_in)
		(cpl_valid_out && cpl_ready_in) |=> done_reg
		##0 !cpl_valid_out [*2])
		else $error("completion posted more than once");

	a_go_to_fetch: assert property (@(posedge clock_in) disable iff (rst_in)
		(state_reg == S_IDLE && go_reg
		&& !rrc_action_reserved(dw10_reg.release_action))
		|=> ##1 mem_req_valid_out && mem_req_addr_out == addr0[ADDR_W-1:0])
		else $error("structure read not issued at pointer");

	a_bus_one_wait: assert property (@(posedge clock_in) disable iff (rst_in)
		(avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out)
		else $error("bus wait longer than one cycle");
endmodule // rrc_release
`default_nettype wire

// file: rrc_host_mem.sv
// host memory model answering the block's 32-bit read requests
`timescale 1ns/1ps
`default_nettype none
module rrc_host_mem #(
	parameter int unsigned ADDR_W = 64
)(
	input  wire logic              clock_in,
	input  wire logic              rst_in,
	input  wire logic              stall_in,
	input  wire logic              req_valid_in,
	output logic                   req_ready_out,
	input  wire logic [ADDR_W-1:0] req_addr_in,
	output logic                   rsp_valid_out,
	output logic [31:0]            rsp_data_out,
	input  wire logic [63:0]       key_in,
	input  wire logic [ADDR_W-1:0] lo_addr_in,
	input  wire logic [ADDR_W-1:0] hi_addr_in
);
	logic [31:0] pend_q[$]; // answers owed, in request order
	// stalls on both the request and the answer side
	assign req_ready_out = ~stall_in;
	// a wrong address gets junk, so a bad fetch shows as a key mismatch
	always @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rsp_valid_out <= 1'b0;
			rsp_data_out <= 32'h0;
			pend_q.delete();
		end
		else
		begin
			if (pend_q.size() != 0 && !stall_in)
			begin
				rsp_valid_out <= 1'b1;
				rsp_data_out <= pend_q.pop_front();
			end
			else
			begin
				rsp_valid_out <= 1'b0;
				rsp_data_out <= ~rsp_data_out; // released line
			end
			if (req_valid_in && req_ready_out)
				pend_q.push_back(req_addr_in == lo_addr_in ? key_in[31:0] :
					req_addr_in == hi_addr_in ? key_in[63:32] : 32'h0bad0bad);
		end
	end
endmodule // rrc_host_mem
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the reservation release block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rrc_pkg::*;
	logic        clock_in, rst_in, stall, cpl_ready;
	logic [7:0]  avs_address;
	logic        avs_read, avs_write, avs_wait, req_v, req_r, rsp_v, cpl_v;
	logic [31:0] avs_wdata, avs_rdata, rsp_d, rq;
	logic [63:0] req_a, mkey, lo_a, hi_a, exp_gen;
	rrc_cpl_t    cpl_e;
	rrc_cpl_t    exp_q[$]; // expected completions, oldest first
	int          n_fail, total_checks, cyc, seed;
	localparam logic [63:0] K = 64'h0123456789abcdef;
	rrc_release dut (.clock_in(clock_in), .rst_in(rst_in),
		.avs_address_in(avs_address), .avs_read_in(avs_read),
		.avs_write_in(avs_write), .avs_writedata_in(avs_wdata),
		.avs_byteenable_in(4'hf), .avs_readdata_out(avs_rdata),
		.avs_waitrequest_out(avs_wait), .mem_req_valid_out(req_v),
		.mem_req_ready_in(req_r), .mem_req_addr_out(req_a),
		.mem_rsp_valid_in(rsp_v), .mem_rsp_data_in(rsp_d),
		.cpl_valid_out(cpl_v), .cpl_entry_out(cpl_e), .cpl_ready_in(cpl_ready));
	rrc_host_mem host (.clock_in(clock_in), .rst_in(rst_in), .stall_in(stall),
		.req_valid_in(req_v), .req_ready_out(req_r), .req_addr_in(req_a),
		.rsp_valid_out(rsp_v), .rsp_data_out(rsp_d), .key_in(mkey),
		.lo_addr_in(lo_a), .hi_addr_in(hi_a));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// holds the request until waitrequest is low at a rising edge;
	// read data taken at that same edge, release right after it
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		avs_read <= ~w;
		avs_write <= w;
		avs_address <= a;
		avs_wdata <= d;
		do @(posedge clock_in); while (avs_wait !== 1'b0);
		rq = avs_rdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// one command: setup, go, poll, then check status, kind and counter
	task automatic run(input logic [31:0] dw, input logic [127:0] p,
		input logic sgl, input logic [63:0] hia, input logic [7:0] ex,
		input logic [7:0] eh, input logic [15:0] qid);
		lo_a <= p[63:0];
		hi_a <= hia;
		bus(1'b1, OFS_HELD, 32'h2);
		bus(1'b1, OFS_QID, {16'h0, qid});
		bus(1'b1, OFS_DW10, dw);
		for (int i = 0; i < 4; i++)
			bus(1'b1, 8'(OFS_PTR0 + 8'(4 * i)), p[32*i +: 32]);
		exp_q.push_back({qid, ex});
		bus(1'b1, OFS_CTRL, {30'h0, sgl, 1'b1});
		for (int i = 0; i < 300; i++)
		begin
			bus(1'b0, OFS_STATUS, 32'h0);
			if (rq[1:0] === 2'b10)
				break;
		end
		chk("status", {16'h0, ex, 8'h02}, rq & 32'h0000ff03);
		bus(1'b0, OFS_HELD, 32'h0);
		chk("held", {24'h0, eh}, rq);
		bus(1'b0, OFS_GEN, 32'h0);
		chk("gen", exp_gen[31:0], rq);
		bus(1'b1, OFS_STATUS, 32'h2);
		$display("test dw10 %h done", dw);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// completion watcher, compares each handshake with the oldest note
	always @(posedge clock_in)
	begin
		cyc++;
		stall <= ($random(seed) & 3) == 0;
		cpl_ready <= ($random(seed) & 3) != 0;
		if (cpl_v === 1'b1 && cpl_ready === 1'b1)
			chk("cpl", exp_q.size() ? 32'(exp_q.pop_front()) : 32'hx, 32'(cpl_e));
		if (cyc == 20000)
		begin
			n_fail++;
			conclude();
		end
	end
	initial
	begin
		clock_in = 0;
		forever #25 clock_in = ~clock_in;
	end
	initial
	begin
		seed = 40919;
		{n_fail, total_checks, cyc} = 0;
		{avs_read, avs_write, stall, cpl_ready} = 0;
		{avs_address, avs_wdata, lo_a, hi_a} = 0;
		mkey = K;
		rst_in = 1;
		repeat (5) @(posedge clock_in);
		rst_in <= 0;
		bus(1'b0, OFS_STATUS, 32'h0);
		chk("reset status", 32'h0, rq);
		bus(1'b0, 8'hfc, 32'h0);
		chk("unmapped", 32'h0, rq);
		bus(1'b0, OFS_GEN, 32'h0);
		exp_gen = {32'h0, rq};
		bus(1'b1, OFS_KEY_LO, K[31:0]);
		bus(1'b1, OFS_KEY_HI, K[63:32]);
		run(32'h200, {64'h0, 64'h10000100}, 0, 64'h10000104, SC_SUCCESS, 8'h0, 16'h11);
		run(32'h500, {64'h0, 64'h10000100}, 0, 64'h10000104, SC_INVALID_FIELD, 8'h2, 16'h12);
		mkey = K ^ 64'h1;
		run(32'h200, {64'h0, 64'h10000100}, 0, 64'h10000104, SC_RES_CONFLICT, 8'h2, 16'h13);
		run(32'h208, {64'h30000000, 64'h20000ffc}, 0, 64'h30000000, SC_SUCCESS, 8'h0, 16'h14);
		mkey = K;
		exp_gen = exp_gen + 1;
		run(32'h1, {64'h0, 64'h20000ffc}, 1, 64'h20001000, SC_SUCCESS, 8'h0, 16'h15);
		for (int a = 2; a < 8; a++)
			run({16'h0, 8'h02, 5'h0, a[2:0]}, {64'h0, 64'h100}, 0, 64'h104, SC_INVALID_FIELD, 8'h2, 16'(a));
		conclude();
	end
endmodule // tb_top
`default_nettype wire
